// ---- verilog/power_mode_reset_control.sv ----
// Power-mode decode, output pin gating, interrupt and user-port pulse logic.
`timescale 1ns/1ps
`default_nettype none
module power_mode_reset_control #(
  parameter int IRQ_MAX_CYC = pmrc_pkg::IRQ_MAX_CYC,
  parameter int USER_MAX_CYC = pmrc_pkg::USER_MAX_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic power_down_n,
  input wire logic [pmrc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pmrc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pmrc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic pll_locked,
  input wire logic clock_loopback,
  input wire logic ref_clock_in,
  input wire logic clk_switching,
  input wire logic fs_tick,
  input wire logic fs_valid,
  input wire logic [7:0] fs_khz,
  input wire logic core_irq,
  input wire logic [15:0] q_status_word,
  input wire pmrc_pkg::core_pins_t core_pins,
  output logic audio_flag_out,
  output logic error_out,
  output logic event_pin_out,
  output logic user_port_out,
  output logic master_clock_out,
  output logic bit_clock_out,
  output logic word_clock_out,
  output logic serial_audio_out,
  output logic crystal_drive_out,
  output logic core_clk_en,
  output logic vco_run,
  output logic osc_amp_run,
  output logic divider_run,
  output logic ref_code_ok,
  output logic fs_accept,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset and mode decode.

  // The power-down pin clears every register except the pin flops, which only the system reset clears.
  logic rst_i;
  assign rst_i = srst | ~power_down_n; // R1 R4

  pmrc_pkg::ctrl_t ctrl_reg, ctrl_next;
  pmrc_pkg::mode_t mode;

  // Mode decode; oscillator stop outranks the sleep select.
  always_comb begin
    mode = pmrc_pkg::MODE_NORMAL;
    if (!power_down_n) begin
      mode = pmrc_pkg::MODE_RESET; // R4
    end else if (ctrl_reg.osc_amp_stop && ctrl_reg.vco_halt) begin
      mode = pmrc_pkg::MODE_ALL_STOP; // R12
    end else if (ctrl_reg.osc_amp_stop) begin
      if (ctrl_reg.partial_sleep_select != pmrc_pkg::SLEEP_OFF) begin
        mode = pmrc_pkg::MODE_ALL_STOP; // R7
      end else begin
        mode = pmrc_pkg::MODE_OSC_STOP; // R11
      end
    end else if (ctrl_reg.partial_sleep_select == pmrc_pkg::SLEEP_DIV) begin
      mode = pmrc_pkg::MODE_SLEEP_DIV; // R10
    end else if (ctrl_reg.partial_sleep_select != pmrc_pkg::SLEEP_OFF) begin
      mode = pmrc_pkg::MODE_SLEEP_OSC; // R10
    end else if (ctrl_reg.vco_halt) begin
      mode = pmrc_pkg::MODE_VCO_STOP; // R9
    end
  end

  // Sleep modes, used to blank the Q and status reads.
  logic in_sleep;
  assign in_sleep = (mode == pmrc_pkg::MODE_SLEEP_OSC) ||
                    (mode == pmrc_pkg::MODE_SLEEP_DIV); // R6

  // Reference code check and receive range check.
  function automatic logic ref_valid(input logic [3:0] code);
    case (code)
      pmrc_pkg::REF_11M2896, pmrc_pkg::REF_12M2880,
      pmrc_pkg::REF_16M9344, pmrc_pkg::REF_22M5792,
      pmrc_pkg::REF_24M5760, pmrc_pkg::REF_33M8688: ref_valid = 1'b1;
      default: ref_valid = 1'b0;
    endcase
  endfunction : ref_valid

  function automatic logic fs_in_range(input logic [7:0] khz,
                                       input logic [1:0] lock);
    logic [7:0] top;
    top = (lock == pmrc_pkg::LOCK_WIDE) ? pmrc_pkg::FS_MAX_WIDE_KHZ
                                        : pmrc_pkg::FS_MAX_NARROW_KHZ;
    fs_in_range = (khz >= pmrc_pkg::FS_MIN_KHZ) && (khz <= top);
  endfunction : fs_in_range

  assign ref_code_ok = ref_valid(ctrl_reg.ref_freq_select); // R16
  logic fs_ok;
  assign fs_ok = fs_in_range(fs_khz, ctrl_reg.lock_freq_select); // R17

  ////////////////////////////////////////////////////////////////////////////
  // Register file, interrupt status and mask.

  logic [pmrc_pkg::EV_W-1:0] status_reg, status_next;
  logic [pmrc_pkg::EV_W-1:0] mask_reg, mask_next;
  logic [pmrc_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic fs_accept_reg, fs_accept_next;
  logic locked_reg, switch_reg;
  logic [pmrc_pkg::EV_W-1:0] events;

  assign events[pmrc_pkg::EV_LOCK] = pll_locked ^ locked_reg;
  assign events[pmrc_pkg::EV_SWITCH] = clk_switching & ~switch_reg;
  assign events[pmrc_pkg::EV_RANGE] = fs_valid & ~fs_ok; // R17
  assign events[pmrc_pkg::EV_CORE] = core_irq;

  // Register writes stay open in sleep; a new event beats its own clear.
  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    fs_accept_next = fs_accept_reg;
    rdata_next = '0;
    if (fs_valid) begin
      fs_accept_next = fs_ok; // R17
    end
    if (reg_wr) begin
      case (reg_addr)
        pmrc_pkg::ADDR_CTRL: ctrl_next = reg_wdata; // R8
        pmrc_pkg::ADDR_MASK: mask_next = reg_wdata[pmrc_pkg::EV_W-1:0];
        pmrc_pkg::ADDR_STATUS: status_next = status_reg &
                                 ~reg_wdata[pmrc_pkg::EV_W-1:0];
        default: ;
      endcase
    end
    status_next = status_next | events;
    if (reg_rd) begin
      case (reg_addr)
        pmrc_pkg::ADDR_CTRL: rdata_next = ctrl_reg;
        pmrc_pkg::ADDR_STATUS: rdata_next = {12'h000, status_reg};
        pmrc_pkg::ADDR_MASK: rdata_next = {12'h000, mask_reg};
        pmrc_pkg::ADDR_QDATA: rdata_next = in_sleep ? 16'h0000
                                                    : q_status_word; // R8
        pmrc_pkg::ADDR_STATE: rdata_next = {8'h00, fs_accept_reg,
                                 ref_code_ok, pll_locked, 2'b00, mode};
        default: rdata_next = '0;
      endcase
    end
  end

  // Everything here clears while the power-down pin is low.
  always_ff @(posedge mclk) begin
    if (rst_i) begin // R4
      ctrl_reg <= pmrc_pkg::CTRL_RESET;
      mask_reg <= '0;
      status_reg <= '0;
      rdata_reg <= '0;
      fs_accept_reg <= 1'b0;
      locked_reg <= 1'b0;
      switch_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      status_reg <= status_next;
      rdata_reg <= rdata_next;
      fs_accept_reg <= fs_accept_next;
      locked_reg <= pll_locked;
      switch_reg <= clk_switching;
    end
  end

  assign reg_rdata = rdata_reg;
  assign fs_accept = fs_accept_reg;
  assign irq = |(status_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pin pulse and user-port pulse timers.

  logic [12:0] pcnt_reg, pcnt_next;
  logic pulse_reg, pulse_next;
  logic [23:0] ucnt_reg, ucnt_next;
  logic upulse_reg, upulse_next;
  logic pulse_mode;
  assign pulse_mode = ctrl_reg.irq_pulse_option & ctrl_reg.irq_select_option;

  // A pulse ends at the first sample tick past the floor, or at the ceiling.
  always_comb begin
    pulse_next = pulse_reg;
    pcnt_next = pcnt_reg;
    if (pulse_reg) begin
      pcnt_next = pcnt_reg + 13'd1;
      if ((fs_tick && pcnt_reg >= 13'(pmrc_pkg::IRQ_MIN_CYC - 1)) ||
          pcnt_reg >= 13'(IRQ_MAX_CYC - 1)) begin // R14
        pulse_next = 1'b0;
      end
    end else if (pulse_mode && |events) begin
      pulse_next = 1'b1;
      pcnt_next = '0;
    end
  end

  // The low pulse is cut at its ceiling even if switching lingers.
  always_comb begin
    upulse_next = upulse_reg;
    ucnt_next = ucnt_reg;
    if (upulse_reg) begin
      ucnt_next = ucnt_reg + 24'd1;
      if (!clk_switching || ucnt_reg >= 24'(USER_MAX_CYC - 1)) begin // R15
        upulse_next = 1'b0;
      end
    end else if (events[pmrc_pkg::EV_SWITCH] && ctrl_reg.user_switch_mode) begin
      upulse_next = 1'b1;
      ucnt_next = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst_i) begin
      pulse_reg <= 1'b0;
      pcnt_reg <= '0;
      upulse_reg <= 1'b0;
      ucnt_reg <= '0;
    end else begin
      pulse_reg <= pulse_next;
      pcnt_reg <= pcnt_next;
      upulse_reg <= upulse_next;
      ucnt_reg <= ucnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Circuit enables and output pin levels per mode.

  logic clocks_dead;
  // Without a lock the stopped oscillator leaves no reference at all.
  assign clocks_dead = (mode == pmrc_pkg::MODE_OSC_STOP) && !pll_locked; // R11

  always_comb begin
    core_clk_en = 1'b0;
    vco_run = 1'b0;
    osc_amp_run = 1'b0;
    divider_run = 1'b0;
    case (mode)
      pmrc_pkg::MODE_RESET: osc_amp_run = 1'b1; // R5
      pmrc_pkg::MODE_NORMAL: begin
        core_clk_en = 1'b1;
        vco_run = 1'b1;
        osc_amp_run = 1'b1;
        divider_run = 1'b1;
      end
      pmrc_pkg::MODE_VCO_STOP: begin // R9
        core_clk_en = 1'b1;
        osc_amp_run = 1'b1;
        divider_run = 1'b1;
      end
      pmrc_pkg::MODE_SLEEP_OSC: osc_amp_run = 1'b1; // R10
      pmrc_pkg::MODE_SLEEP_DIV: begin // R10
        osc_amp_run = 1'b1;
        divider_run = 1'b1;
      end
      pmrc_pkg::MODE_OSC_STOP: begin // R11
        core_clk_en = pll_locked;
        vco_run = 1'b1;
        divider_run = pll_locked;
      end
      default: ; // Both stops and the PLL stays held.
    endcase
  end

  logic audio_reg, error_reg, event_reg, user_reg, mco_reg;
  logic bck_reg, lrck_reg, sdo_reg, xdrv_reg;
  logic audio_next, error_next, event_next, user_next, mco_next;
  logic bck_next, lrck_next, sdo_next, xdrv_next;
  logic event_src;
  assign event_src = pulse_mode ? pulse_reg : irq;

  // Pin levels; bit and word clocks keep their last level in full stop.
  always_comb begin
    audio_next = core_pins.audio;
    error_next = core_pins.error;
    event_next = event_src;
    user_next = upulse_reg ? 1'b0 : core_pins.user_port; // R15
    mco_next = core_pins.mclk_out;
    bck_next = core_pins.bit_clk;
    lrck_next = core_pins.word_clk;
    sdo_next = core_pins.data;
    xdrv_next = ~ref_clock_in;
    case (mode)
      pmrc_pkg::MODE_RESET: begin
        {audio_next, event_next, mco_next} = 3'b000;
        {bck_next, lrck_next, sdo_next} = 3'b000;
        {error_next, user_next, xdrv_next} = 3'b111;
      end
      pmrc_pkg::MODE_VCO_STOP: begin
        {audio_next, event_next, error_next} = 3'b001; // R9
        if (clock_loopback) begin
          {mco_next, bck_next, lrck_next} = 3'b000; // R13
        end
      end
      pmrc_pkg::MODE_SLEEP_OSC: begin
        {audio_next, event_next, error_next} = 3'b001;
        {bck_next, lrck_next, sdo_next} = 3'b000; // R10
      end
      pmrc_pkg::MODE_SLEEP_DIV: begin
        {audio_next, event_next, error_next} = 3'b001;
      end
      pmrc_pkg::MODE_OSC_STOP: begin
        xdrv_next = 1'b1; // R11
        if (clocks_dead) begin
          {audio_next, event_next, error_next} = 3'b001;
          {mco_next, sdo_next} = 2'b00;
          {bck_next, lrck_next} = {bck_reg, lrck_reg};
        end
      end
      pmrc_pkg::MODE_ALL_STOP: begin // R12
        {audio_next, event_next, error_next} = 3'b001;
        {mco_next, sdo_next, xdrv_next} = 3'b001;
        {bck_next, lrck_next} = {bck_reg, lrck_reg};
      end
      default: ;
    endcase
  end

  // Pins are flopped on the system reset only, so the reset levels above
  // come from the mode decode while the power-down pin is low.
  always_ff @(posedge mclk) begin
    if (srst) begin
      {audio_reg, event_reg, mco_reg, bck_reg} <= 4'h0;
      {lrck_reg, sdo_reg} <= 2'b00;
      {error_reg, user_reg, xdrv_reg} <= 3'b111;
    end else begin
      audio_reg <= audio_next;
      error_reg <= error_next;
      event_reg <= event_next;
      user_reg <= user_next;
      mco_reg <= mco_next;
      bck_reg <= bck_next;
      lrck_reg <= lrck_next;
      sdo_reg <= sdo_next;
      xdrv_reg <= xdrv_next;
    end
  end

  assign audio_flag_out = audio_reg;
  assign error_out = error_reg;
  assign event_pin_out = event_reg;
  assign user_port_out = user_reg;
  assign master_clock_out = mco_reg;
  assign bit_clock_out = bck_reg;
  assign word_clock_out = lrck_reg;
  assign serial_audio_out = sdo_reg;
  assign crystal_drive_out = xdrv_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_pwrdn_low2;
    !power_down_n [*2];
  endsequence

  AST_PWRDN_CLEARS: assert property (!power_down_n |=> ctrl_reg == '0 && !irq) // R4
    else $error("registers not cleared under power down");
  AST_PWRDN_PINS: assert property (s_pwrdn_low2 |-> !master_clock_out && error_out // R1
      && crystal_drive_out && !bit_clock_out && !serial_audio_out)
    else $error("reset pin levels wrong");
  AST_SLEEP_ZERO: assert property (reg_rd && reg_addr == pmrc_pkg::ADDR_QDATA // R8
      && in_sleep && power_down_n |=> reg_rdata == '0)
    else $error("q data not blanked in sleep");
  AST_OSC_WINS: assert property (ctrl_reg.osc_amp_stop && // R7
      ctrl_reg.partial_sleep_select != pmrc_pkg::SLEEP_OFF |-> !vco_run && !core_clk_en)
    else $error("oscillator stop did not take precedence");
  AST_VCO_PINS: assert property (mode == pmrc_pkg::MODE_VCO_STOP |=> // R9
      !audio_flag_out && !event_pin_out && error_out)
    else $error("vco halt pin levels wrong");
  AST_SLEEP_OSC: assert property (mode == pmrc_pkg::MODE_SLEEP_OSC |=> // R10
      !bit_clock_out && !word_clock_out && !serial_audio_out)
    else $error("sleep select 01 outputs not low");
  AST_HOLD: assert property (mode == pmrc_pkg::MODE_ALL_STOP [*2] |-> // R12
      $stable(bit_clock_out) && $stable(word_clock_out) && !master_clock_out)
    else $error("bit or word clock moved in full stop");
  AST_LOOP: assert property (mode == pmrc_pkg::MODE_VCO_STOP && clock_loopback // R13
      |=> !master_clock_out)
    else $error("clock driven with loopback and vco halted");
  AST_PULSE_MAX: assert property (pulse_reg |-> pcnt_reg < 13'(IRQ_MAX_CYC)) // R14
    else $error("interrupt pulse too long");
  AST_PULSE_MIN: assert property (pulse_reg && !pulse_next // R14
      |-> pcnt_reg >= 13'(pmrc_pkg::IRQ_MIN_CYC - 1)) else $error("interrupt pulse too short");
  AST_USER_MAX: assert property (upulse_reg |-> ucnt_reg < 24'(USER_MAX_CYC)) // R15
    else $error("user port pulse too long");
  AST_RANGE: assert property (fs_valid && fs_khz > pmrc_pkg::FS_MAX_NARROW_KHZ // R17
      && ctrl_reg.lock_freq_select != pmrc_pkg::LOCK_WIDE |=> !fs_accept
      && status_reg[pmrc_pkg::EV_RANGE])
    else $error("out of range rate accepted");

endmodule : power_mode_reset_control
`default_nettype wire

// ---- pkg/pmrc_pkg.sv ----
// Constants, types and register map of the power-mode and reset control block.
// Notes on behaviour
// [R1] Run only while power_down_n high; low resets.
// [R2] Host holds power_down_n low during power-up.
// [R3] Host waits 10 ms after release with crystal.
// [R4] power_down_n low stops clocks, clears all registers.
// [R5] In reset only oscillator amplifier may run.
// [R6] Partial sleep keeps only clock, data, crystal pins.
// [R7] Oscillator stop wins in sleep; PLL held stopped.
// [R8] Sleep accepts writes; Q and status read zero.
// [R9] VCO halt: reference clock, audio/irq low, error high.
// [R10] Select 01 lowers clocks/data; 10 keeps them.
// [R11] Oscillator stop: crystal high, run only when locked.
// [R12] Both stops: halt, clock/data low, bit/word hold.
// [R13] Looped-back clock with VCO halted: no clocks.
// [R14] Interrupt pulse one sample, 5 to 63 us.
// [R15] User port low pulse at switch, max 100 ms.
// [R16] Reference select codes map to six frequencies.
// [R17] Lock select 00 accepts 30-195 kHz, else 30-108.
package pmrc_pkg;

  localparam int CLK_MHZ = 100;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register word indices.
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_MASK = 4'h2;
  localparam logic [3:0] ADDR_QDATA = 4'h3;
  localparam logic [3:0] ADDR_STATE = 4'h4;

  // Status and mask bit positions.
  localparam int EV_LOCK = 0;
  localparam int EV_SWITCH = 1;
  localparam int EV_RANGE = 2;
  localparam int EV_CORE = 3;
  localparam int EV_W = 4;

  // Control word after reset.
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // Timing in printed units and in clock cycles.
  localparam int CRYSTAL_SETTLE_MS = 10;
  localparam int IRQ_MIN_US = 5;
  localparam int IRQ_MAX_US = 63;
  localparam int USER_MAX_MS = 100;
  localparam int IRQ_MIN_CYC = IRQ_MIN_US * CLK_MHZ;
  localparam int IRQ_MAX_CYC = IRQ_MAX_US * CLK_MHZ;
  localparam int USER_MAX_CYC = USER_MAX_MS * 1000 * CLK_MHZ;

  // Receive range limits in kHz.
  localparam logic [7:0] FS_MIN_KHZ = 8'd30;
  localparam logic [7:0] FS_MAX_WIDE_KHZ = 8'd195;
  localparam logic [7:0] FS_MAX_NARROW_KHZ = 8'd108;
  localparam logic [1:0] LOCK_WIDE = 2'b00;

  // Reference frequency select codes.
  localparam logic [3:0] REF_11M2896 = 4'h0;
  localparam logic [3:0] REF_12M2880 = 4'h1;
  localparam logic [3:0] REF_16M9344 = 4'h2;
  localparam logic [3:0] REF_22M5792 = 4'h4;
  localparam logic [3:0] REF_24M5760 = 4'h5;
  localparam logic [3:0] REF_33M8688 = 4'h6;

  // Partial sleep select codes.
  localparam logic [1:0] SLEEP_OFF = 2'b00;
  localparam logic [1:0] SLEEP_OSC = 2'b01;
  localparam logic [1:0] SLEEP_DIV = 2'b10;

  typedef enum logic [2:0] {
    MODE_RESET = 3'b000,
    MODE_NORMAL = 3'b001,
    MODE_VCO_STOP = 3'b010,
    MODE_SLEEP_OSC = 3'b011,
    MODE_SLEEP_DIV = 3'b100,
    MODE_OSC_STOP = 3'b101,
    MODE_ALL_STOP = 3'b110
  } mode_t;

  typedef struct packed {
    logic [2:0] spare;
    logic user_switch_mode;
    logic irq_select_option;
    logic irq_pulse_option;
    logic [1:0] lock_freq_select;
    logic [3:0] ref_freq_select;
    logic [1:0] partial_sleep_select;
    logic vco_halt;
    logic osc_amp_stop;
  } ctrl_t;

  typedef struct packed {
    logic audio;
    logic error;
    logic bit_clk;
    logic word_clk;
    logic data;
    logic mclk_out;
    logic user_port;
  } core_pins_t;

endpackage : pmrc_pkg

// ---- verif/host_model.sv ----
// Host controller model: owns the power-down pin and the register port.
`timescale 1ns/1ps
`default_nettype none
module host_model #(
  parameter int SETTLE_CYC = 20
) (
  input wire logic mclk,
  output logic power_down_n,
  output logic [pmrc_pkg::ADDR_W-1:0] reg_addr,
  output logic [pmrc_pkg::DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [pmrc_pkg::DATA_W-1:0] reg_rdata
);
  ////////////////////////////////////////////////////////////////
  // The pin is low from time zero so the device powers up in reset.
  initial begin
    power_down_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Settle wait is shortened; a real crystal needs far longer.
  task automatic power_up();
    @(posedge mclk);
    power_down_n <= 1'b1;
    repeat (SETTLE_CYC) @(posedge mclk);
  endtask : power_up

  // Pulls the pin low again for a full reset.
  task automatic power_cut();
    @(posedge mclk);
    power_down_n <= 1'b0;
  endtask : power_cut

  // One-cycle write strobe with address and data beside it.
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so take them mid-cycle.
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    v = reg_rdata;
  endtask : rd
endmodule : host_model
`default_nettype wire

// ---- verif/power_mode_reset_control_tb.sv ----
// Self-checking bench for the power-mode and reset control block.
`timescale 1ns/1ps
`default_nettype none
module power_mode_reset_control_tb;
  localparam int USER_CYC = 50;
  logic mclk, srst, pll_locked, clock_loopback, ref_clock_in, clk_switching;
  logic fs_tick, fs_valid, core_irq, power_down_n, reg_wr, reg_rd;
  logic [7:0] fs_khz;
  logic [3:0] reg_addr;
  logic [15:0] q_status_word, reg_wdata, reg_rdata, d;
  pmrc_pkg::core_pins_t core_pins;
  logic audio_flag_out, error_out, event_pin_out, user_port_out, master_clock_out;
  logic bit_clock_out, word_clock_out, serial_audio_out, crystal_drive_out;
  logic vco_run, osc_amp_run, ref_code_ok, fs_accept, irq, core_clk_en, divider_run;
  wire logic [6:0] pins;
  int fail_count, num_checks;

  // Pin group compared as one word.
  assign pins = {audio_flag_out, error_out, bit_clock_out, word_clock_out,
                 serial_audio_out, master_clock_out, crystal_drive_out};

  ////////////////////////////////////////////////////////////////
  // Short counts keep pulse tests brief.
  power_mode_reset_control #(.IRQ_MAX_CYC(600), .USER_MAX_CYC(USER_CYC))
    i_power_mode_reset_control (
    .mclk(mclk), .srst(srst), .power_down_n(power_down_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pll_locked(pll_locked), .clock_loopback(clock_loopback), .ref_clock_in(ref_clock_in),
    .clk_switching(clk_switching), .fs_tick(fs_tick), .fs_valid(fs_valid), .fs_khz(fs_khz),
    .core_irq(core_irq), .q_status_word(q_status_word), .core_pins(core_pins),
    .audio_flag_out(audio_flag_out), .error_out(error_out), .event_pin_out(event_pin_out),
    .user_port_out(user_port_out), .master_clock_out(master_clock_out),
    .bit_clock_out(bit_clock_out), .word_clock_out(word_clock_out),
    .serial_audio_out(serial_audio_out), .crystal_drive_out(crystal_drive_out),
    .core_clk_en(core_clk_en), .vco_run(vco_run), .osc_amp_run(osc_amp_run),
    .divider_run(divider_run), .ref_code_ok(ref_code_ok), .fs_accept(fs_accept), .irq(irq));

  host_model i_host_model (.mclk(mclk), .power_down_n(power_down_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////
  // Compares settle in mid-cycle, away from the sampling edge.
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : settle

  // Single compare for every kind of result.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One-cycle interrupt event from the core.
  task automatic pulse_irq();
    @(posedge mclk);
    core_irq <= 1'b1;
    @(posedge mclk);
    core_irq <= 1'b0;
  endtask : pulse_irq

  // Lock held and reference high, so a stopped oscillator shows a high crystal pin.
  task automatic test_modes();
    logic [15:0] ctl [7] = '{16'h0000, 16'h0002, 16'h0004, 16'h0008, 16'h0001, 16'h0003, 16'h0005};
    logic [2:0] md [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h6};
    logic [6:0] pv [7] = '{7'h5e, 7'h3e, 7'h22, 7'h3e, 7'h5f, 7'h39, 7'h39};
    for (int i = 0; i < 7; i++) begin
      i_host_model.wr(pmrc_pkg::ADDR_CTRL, ctl[i]);
      settle(4);
      chk({9'h000, pins}, {9'h000, pv[i]});
      i_host_model.rd(pmrc_pkg::ADDR_STATE, d);
      chk({13'h0000, d[2:0]}, {13'h0000, md[i]});
    end
    chk({13'h0000, vco_run, core_clk_en, divider_run}, 16'h0000);
    core_pins <= 7'h00;
    settle(3);
    chk({9'h000, pins}, 16'h0039);
    core_pins <= 7'h5e;
    i_host_model.wr(pmrc_pkg::ADDR_CTRL, 16'h0000);
    pll_locked <= 1'b0;
    i_host_model.wr(pmrc_pkg::ADDR_CTRL, 16'h0001);
    settle(4);
    chk({9'h000, pins}, 16'h0039);
    pll_locked <= 1'b1;
    clock_loopback <= 1'b1;
    i_host_model.wr(pmrc_pkg::ADDR_CTRL, 16'h0002);
    settle(4);
    chk({12'h000, master_clock_out, vco_run, core_clk_en, divider_run}, 16'h0003);
    clock_loopback <= 1'b0;
  endtask : test_modes

  // Sleep keeps writes but blanks Q data; unmapped reads are zero.
  task automatic test_qdata();
    i_host_model.wr(pmrc_pkg::ADDR_CTRL, 16'h0000);
    i_host_model.rd(pmrc_pkg::ADDR_QDATA, d);
    chk(d, 16'hbeef);
    for (int i = 1; i < 3; i++) begin
      i_host_model.wr(pmrc_pkg::ADDR_CTRL, {12'h000, i[1:0], 2'h0});
      i_host_model.rd(pmrc_pkg::ADDR_QDATA, d);
      chk(d, 16'h0000);
      i_host_model.wr(pmrc_pkg::ADDR_MASK, 16'h0005);
      i_host_model.rd(pmrc_pkg::ADDR_MASK, d);
      chk(d, 16'h0005);
    end
    i_host_model.rd(4'hf, d);
    chk(d, 16'h0000);
    i_host_model.wr(pmrc_pkg::ADDR_CTRL, 16'h0000);
  endtask : test_qdata

  // Sticky status, mask gating and write-one clear of the level output.
  task automatic test_irq();
    i_host_model.wr(pmrc_pkg::ADDR_MASK, 16'h0000);
    i_host_model.wr(pmrc_pkg::ADDR_STATUS, 16'h000f);
    pulse_irq();
    settle(2);
    chk({15'h0000, irq}, 16'h0000);
    i_host_model.rd(pmrc_pkg::ADDR_STATUS, d);
    chk(d, 16'h0008);
    i_host_model.wr(pmrc_pkg::ADDR_MASK, 16'h0008);
    settle(2);
    chk({14'h0000, irq, event_pin_out}, 16'h0003);
    i_host_model.wr(pmrc_pkg::ADDR_STATUS, 16'h0008);
    settle(2);
    chk({15'h0000, irq}, 16'h0000);
  endtask : test_irq

  // Pulse width must stay between 5 us and the short maximum, with and without ticks.
  task automatic test_pulse();
    int w;
    int p;
    i_host_model.wr(pmrc_pkg::ADDR_CTRL, 16'h0c00);
    for (int k = 0; k < 2; k++) begin
      p = (k == 0) ? 130 : 0;
      w = 0;
      pulse_irq();
      for (int i = 0; i < 900; i++) begin
        @(negedge mclk);
        if (event_pin_out === 1'b1) w++;
        @(posedge mclk);
        fs_tick <= (p != 0) && (i % 130 == 129);
      end
      chk({15'h0000, (w >= 500) && (w <= 600)}, 16'h0001);
      i_host_model.wr(pmrc_pkg::ADDR_STATUS, 16'h000f);
    end
    i_host_model.wr(pmrc_pkg::ADDR_CTRL, 16'h0000);
  endtask : test_pulse

  // A long switch must not stretch the low pulse past its limit.
  task automatic test_user();
    int w = 0;
    core_pins <= 7'h5f;
    i_host_model.wr(pmrc_pkg::ADDR_CTRL, 16'h1000);
    @(posedge mclk);
    clk_switching <= 1'b1;
    for (int i = 0; i < 200; i++) begin
      settle(0);
      if (user_port_out === 1'b0) w++;
      @(posedge mclk);
    end
    clk_switching <= 1'b0;
    chk({15'h0000, (w >= 1) && (w <= USER_CYC)}, 16'h0001);
    core_pins <= 7'h5e;
    i_host_model.wr(pmrc_pkg::ADDR_CTRL, 16'h0000);
  endtask : test_user

  // Every reference code, both edges of the wide receive range and the top edge of the narrow one.
  task automatic test_codes();
    logic [1:0] lk [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    logic [7:0] kz [8] = '{8'hc3, 8'hc4, 8'h1e, 8'h1d, 8'h6c, 8'h6d, 8'h6c, 8'h6d};
    logic ex [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int c = 0; c < 16; c++) begin
      i_host_model.wr(pmrc_pkg::ADDR_CTRL, {8'h00, c[3:0], 4'h0});
      settle(1);
      chk({15'h0000, ref_code_ok}, {15'h0000, c inside {0, 1, 2, 4, 5, 6}});
    end
    for (int i = 0; i < 8; i++) begin
      i_host_model.wr(pmrc_pkg::ADDR_CTRL, {6'h00, lk[i], 8'h00});
      @(posedge mclk);
      fs_khz <= kz[i];
      fs_valid <= 1'b1;
      @(posedge mclk);
      fs_valid <= 1'b0;
      settle(2);
      chk({15'h0000, fs_accept}, {15'h0000, ex[i]});
    end
  endtask : test_codes

  // Power-down low: reset pin levels, oscillator running, registers cleared.
  task automatic test_power_cut();
    i_host_model.wr(pmrc_pkg::ADDR_CTRL, 16'h0002);
    i_host_model.power_cut();
    settle(3);
    chk({7'h00, pins, user_port_out, osc_amp_run}, 16'h0087);
    i_host_model.power_up();
    i_host_model.rd(pmrc_pkg::ADDR_CTRL, d);
    chk(d, 16'h0000);
  endtask : test_power_cut

  ////////////////////////////////////////////////////////////////
  // Reports the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // Main sequence; inputs get a value at time zero.
  initial begin
    srst = 1'b1;
    pll_locked = 1'b1;
    clock_loopback = 1'b0;
    ref_clock_in = 1'b1;
    clk_switching = 1'b0;
    fs_tick = 1'b0;
    fs_valid = 1'b0;
    fs_khz = 8'h00;
    core_irq = 1'b0;
    q_status_word = 16'hbeef;
    core_pins = 7'h5e;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    settle(3);
    chk({7'h00, pins, user_port_out, event_pin_out}, 16'h0086);
    i_host_model.power_up();
    test_modes();
    test_qdata();
    test_irq();
    test_pulse();
    test_user();
    test_codes();
    test_power_cut();
    stop_test();
  end

  // Watchdog well beyond the few thousand cycles the tests need.
  initial begin
    #500000;
    fail_count++;
    stop_test();
  end
endmodule : power_mode_reset_control_tb
`default_nettype wire
